/* src/ofd_pkg.sv */
package ofd_pkg;
    // ====================================================================
    // register offsets
    localparam logic [15:0] ADDR_APP_MODE = 16'h0200;
    localparam logic [15:0] ADDR_DEC_RATIO = 16'h0201;
    localparam logic [15:0] ADDR_UPPER_LO = 16'h0247;
    localparam logic [15:0] ADDR_UPPER_HI = 16'h0248;
    localparam logic [15:0] ADDR_LOWER_LO = 16'h0249;
    localparam logic [15:0] ADDR_LOWER_HI = 16'h024A;
    localparam logic [15:0] ADDR_DWELL_LO = 16'h024B;
    localparam logic [15:0] ADDR_DWELL_HI = 16'h024C;
    localparam logic [15:0] ADDR_OVR_CLEAR = 16'h0562;
    localparam logic [15:0] ADDR_OVR_STATUS = 16'h0563;
    // ====================================================================
    // fields and constants
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int QIGN_BIT = 5;
    localparam int RATIO_W = 4;
    localparam int SAMPLE_W = 14;
    localparam int MAG_W = 13;
    localparam int NUM_VC = 8;
    localparam int NUM_DDC = 4;
    localparam int FD_LATENCY_MAX = 28;
    localparam logic [3:0] MODE_FULL = 4'h0;
    localparam logic [3:0] MODE_DDC1 = 4'h1;
    localparam logic [3:0] MODE_DDC2 = 4'h2;
    localparam logic [3:0] MODE_DDC4 = 4'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] UPPER_RESET = 16'hFFFF;
    localparam logic [15:0] LOWER_RESET = 16'h0000;
    localparam logic [15:0] DWELL_RESET = 16'h0001;
    localparam logic [3:0] RATIO_RESET = 4'h1;
    localparam logic [MAG_W-1:0] MAG_FULL = 13'h1FFF;
    // ====================================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic overrange;
        logic [SAMPLE_W-1:0] data;
    } ofd_sample_t;
    typedef struct packed {
        logic [NUM_VC-1:0] used;
        logic [NUM_VC-1:0] overrange;
        logic [NUM_VC-1:0][SAMPLE_W-1:0] data;
    } ofd_vc_word_t;
endpackage : ofd_pkg

/* src/ofd_top.sv */
// Overview of operation
// - overrange flag travels with its sample through identical pipeline delay
// - overrange placed in control bit when control bits per sample above zero
// - eight sticky overrange bits, one per virtual converter, set by overrange
// - sticky bit cleared when clear bit written one then back to zero
// - threshold flag set when sample magnitude exceeds upper threshold
// - flag cleared only after magnitude stays below lower threshold for dwell
// - upper threshold held in two byte registers, compared with magnitude
// - flag asserts within 28 clocks of crossing sample entering
// - lower threshold is 13-bit magnitude across two bytes, full scale 2^13
// - lower comparison may lag pipeline but uses full resolution
// - dwell is 16-bit count 1 to 65535 across two byte registers
// - independent comparator and flag per channel, each with own pin
// - mode register holds operating mode bits 3:0 and Q-ignore bit 5
// - full bandwidth: ADC A to converter 0, ADC B to converter 1
// - mode codes 1, 2, 3 enable one, two, four downconverters
// - decimation ratio bits 3:0; output rate is sample rate over ratio
// - each real, I or Q stream is its own converter, eight at most
// - complex streams paired: I on lower converter, Q on the next
// - Q-ignore set: I of n to slot n; else I to 2n, Q to 2n+1
module ofd_top #(
    parameter int PIPE_DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] control_bits_per_sample,
    input wire ofd_pkg::ofd_sample_t adc_a,
    input wire ofd_pkg::ofd_sample_t adc_b,
    input wire logic [ofd_pkg::NUM_DDC-1:0][ofd_pkg::SAMPLE_W-1:0] ddc_i,
    input wire logic [ofd_pkg::NUM_DDC-1:0][ofd_pkg::SAMPLE_W-1:0] ddc_q,
    input wire logic ddc_valid,
    output logic threshold_flag_pin_first,
    output logic threshold_flag_pin_second,
    output logic vc_valid,
    input wire logic vc_ready,
    output ofd_pkg::ofd_vc_word_t vc_word,
    output logic [ofd_pkg::NUM_VC-1:0] vc_ctrl_bit,
    output logic [3:0] dec_ratio,
    output logic [3:0] chip_mode,
    output logic in_ready
);
    // ====================================================================
    // register file
    logic [7:0] app_mode_reg;
    logic [3:0] dec_ratio_reg;
    logic [15:0] upper_reg;
    logic [15:0] lower_reg;
    logic [15:0] dwell_reg;
    logic [7:0] ovr_clear_reg;
    logic [7:0] ovr_sticky_reg;
    logic [7:0] rdata_next;

    function automatic logic [ofd_pkg::MAG_W-1:0] mag_of(input logic [ofd_pkg::SAMPLE_W-1:0] s);
        logic [ofd_pkg::SAMPLE_W-1:0] a;
        a = s[ofd_pkg::SAMPLE_W-1] ? (~s + 14'h0001) : s;
        // most negative code saturates to full scale
        mag_of = a[ofd_pkg::SAMPLE_W-1] ? ofd_pkg::MAG_FULL : a[ofd_pkg::MAG_W-1:0];
    endfunction : mag_of

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            app_mode_reg <= ofd_pkg::RESET_BYTE;
            dec_ratio_reg <= ofd_pkg::RATIO_RESET;
            upper_reg <= ofd_pkg::UPPER_RESET;
            lower_reg <= ofd_pkg::LOWER_RESET;
            dwell_reg <= ofd_pkg::DWELL_RESET;
            ovr_clear_reg <= ofd_pkg::RESET_BYTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ofd_pkg::ADDR_APP_MODE: app_mode_reg <= reg_wdata;
                ofd_pkg::ADDR_DEC_RATIO: dec_ratio_reg <= reg_wdata[ofd_pkg::RATIO_W-1:0];
                ofd_pkg::ADDR_UPPER_LO: upper_reg[7:0] <= reg_wdata;
                ofd_pkg::ADDR_UPPER_HI: upper_reg[15:8] <= reg_wdata;
                ofd_pkg::ADDR_LOWER_LO: lower_reg[7:0] <= reg_wdata;
                ofd_pkg::ADDR_LOWER_HI: lower_reg[15:8] <= reg_wdata;
                ofd_pkg::ADDR_DWELL_LO: dwell_reg[7:0] <= reg_wdata;
                ofd_pkg::ADDR_DWELL_HI: dwell_reg[15:8] <= reg_wdata;
                ofd_pkg::ADDR_OVR_CLEAR: ovr_clear_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = ofd_pkg::RESET_BYTE;
        unique case (reg_addr)
            ofd_pkg::ADDR_APP_MODE: rdata_next = app_mode_reg;
            ofd_pkg::ADDR_DEC_RATIO: rdata_next = {4'h0, dec_ratio_reg};
            ofd_pkg::ADDR_UPPER_LO: rdata_next = upper_reg[7:0];
            ofd_pkg::ADDR_UPPER_HI: rdata_next = upper_reg[15:8];
            ofd_pkg::ADDR_LOWER_LO: rdata_next = lower_reg[7:0];
            ofd_pkg::ADDR_LOWER_HI: rdata_next = lower_reg[15:8];
            ofd_pkg::ADDR_DWELL_LO: rdata_next = dwell_reg[7:0];
            ofd_pkg::ADDR_DWELL_HI: rdata_next = dwell_reg[15:8];
            ofd_pkg::ADDR_OVR_CLEAR: rdata_next = ovr_clear_reg;
            ofd_pkg::ADDR_OVR_STATUS: rdata_next = ovr_sticky_reg;
            default: rdata_next = ofd_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= ofd_pkg::RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_ratio <= ofd_pkg::RATIO_RESET;
            chip_mode <= ofd_pkg::MODE_FULL;
        end else begin
            dec_ratio <= dec_ratio_reg;
            chip_mode <= app_mode_reg[ofd_pkg::MODE_LSB +: ofd_pkg::MODE_W];
        end
    end

    // ====================================================================
    // fast threshold detection, one per channel
    logic [1:0][ofd_pkg::SAMPLE_W-1:0] chan_data;
    logic [1:0] chan_valid;
    logic [1:0][ofd_pkg::MAG_W-1:0] mag_reg;
    logic [1:0] mag_valid_reg;
    logic [1:0] flag_reg;
    logic [1:0][15:0] dwell_cnt_reg;

    assign chan_data[0] = adc_a.data;
    assign chan_data[1] = adc_b.data;
    assign chan_valid[0] = adc_a.valid;
    assign chan_valid[1] = adc_b.valid;

    for (genvar c = 0; c < 2; c++) begin : g_fd
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                mag_reg[c] <= '0;
                mag_valid_reg[c] <= 1'b0;
            end else begin
                mag_reg[c] <= mag_of(chan_data[c]);
                mag_valid_reg[c] <= chan_valid[c];
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                flag_reg[c] <= 1'b0;
                dwell_cnt_reg[c] <= 16'h0000;
            end else if (mag_valid_reg[c]) begin
                if ({3'b000, mag_reg[c]} > upper_reg) begin
                    flag_reg[c] <= 1'b1;
                    dwell_cnt_reg[c] <= 16'h0000;
                end else if ({3'b000, mag_reg[c]} >= lower_reg) begin
                    dwell_cnt_reg[c] <= 16'h0000;
                end else if (flag_reg[c]) begin
                    if (dwell_cnt_reg[c] + 16'h0001 >= dwell_reg) begin
                        flag_reg[c] <= 1'b0;
                        dwell_cnt_reg[c] <= 16'h0000;
                    end else begin
                        dwell_cnt_reg[c] <= dwell_cnt_reg[c] + 16'h0001;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            threshold_flag_pin_first <= 1'b0;
            threshold_flag_pin_second <= 1'b0;
        end else begin
            threshold_flag_pin_first <= flag_reg[0];
            threshold_flag_pin_second <= flag_reg[1];
        end
    end

    // ====================================================================
    // sample pipeline; overrange rides alongside the data
    logic [PIPE_DEPTH-1:0][1:0][ofd_pkg::SAMPLE_W-1:0] pipe_data_reg;
    logic [PIPE_DEPTH-1:0][1:0] pipe_ovr_reg;
    logic [PIPE_DEPTH-1:0] pipe_valid_reg;
    logic [PIPE_DEPTH-1:0][ofd_pkg::NUM_DDC-1:0][ofd_pkg::SAMPLE_W-1:0] pipe_i_reg;
    logic [PIPE_DEPTH-1:0][ofd_pkg::NUM_DDC-1:0][ofd_pkg::SAMPLE_W-1:0] pipe_q_reg;
    logic pipe_go;

    assign pipe_go = in_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_data_reg <= '0;
            pipe_ovr_reg <= '0;
            pipe_valid_reg <= '0;
            pipe_i_reg <= '0;
            pipe_q_reg <= '0;
        end else if (pipe_go) begin
            pipe_data_reg[0] <= chan_data;
            pipe_ovr_reg[0] <= {adc_b.overrange, adc_a.overrange};
            pipe_valid_reg[0] <= (chip_mode == ofd_pkg::MODE_FULL) ? adc_a.valid : ddc_valid;
            pipe_i_reg[0] <= ddc_i;
            pipe_q_reg[0] <= ddc_q;
            for (int k = 1; k < PIPE_DEPTH; k++) begin
                pipe_data_reg[k] <= pipe_data_reg[k-1];
                pipe_ovr_reg[k] <= pipe_ovr_reg[k-1];
                pipe_valid_reg[k] <= pipe_valid_reg[k-1];
                pipe_i_reg[k] <= pipe_i_reg[k-1];
                pipe_q_reg[k] <= pipe_q_reg[k-1];
            end
        end
    end

    // ====================================================================
    // virtual converter mapping
    ofd_pkg::ofd_vc_word_t map_word;
    logic [2:0] n_ddc;
    logic q_ignore;
    logic [1:0] ovr_any;

    assign q_ignore = app_mode_reg[ofd_pkg::QIGN_BIT];
    assign ovr_any = pipe_ovr_reg[PIPE_DEPTH-1];

    always_comb begin
        map_word = '0;
        n_ddc = 3'd0;
        unique case (chip_mode)
            ofd_pkg::MODE_DDC1: n_ddc = 3'd1;
            ofd_pkg::MODE_DDC2: n_ddc = 3'd2;
            ofd_pkg::MODE_DDC4: n_ddc = 3'd4;
            default: n_ddc = 3'd0;
        endcase
        if (chip_mode == ofd_pkg::MODE_FULL) begin
            map_word.data[0] = pipe_data_reg[PIPE_DEPTH-1][0];
            map_word.data[1] = pipe_data_reg[PIPE_DEPTH-1][1];
            map_word.used[1:0] = 2'b11;
            map_word.overrange[1:0] = ovr_any;
        end else begin
            for (int n = 0; n < ofd_pkg::NUM_DDC; n++) begin
                if (n < int'(n_ddc)) begin
                    if (q_ignore) begin
                        map_word.data[n] = pipe_i_reg[PIPE_DEPTH-1][n];
                        map_word.used[n] = 1'b1;
                        map_word.overrange[n] = |ovr_any;
                    end else begin
                        map_word.data[2*n] = pipe_i_reg[PIPE_DEPTH-1][n];
                        map_word.data[2*n+1] = pipe_q_reg[PIPE_DEPTH-1][n];
                        map_word.used[2*n] = 1'b1;
                        map_word.used[2*n+1] = 1'b1;
                        map_word.overrange[2*n] = |ovr_any;
                        map_word.overrange[2*n+1] = |ovr_any;
                    end
                end
            end
        end
    end

    // ====================================================================
    // sticky overrange status and clear
    logic [7:0] clear_prev_reg;
    logic [7:0] clear_fall;
    logic [7:0] ovr_set;

    assign clear_fall = clear_prev_reg & ~ovr_clear_reg;
    assign ovr_set = (pipe_valid_reg[PIPE_DEPTH-1] && pipe_go) ? map_word.overrange : 8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clear_prev_reg <= ofd_pkg::RESET_BYTE;
            ovr_sticky_reg <= ofd_pkg::RESET_BYTE;
        end else begin
            clear_prev_reg <= ovr_clear_reg;
            ovr_sticky_reg <= (ovr_sticky_reg & ~clear_fall) | ovr_set;
        end
    end

    // ====================================================================
    // two-entry output buffer
    ofd_pkg::ofd_vc_word_t buf_reg [2];
    logic [1:0] buf_cnt_reg;
    logic buf_rd_reg;
    logic buf_wr_reg;
    logic push;
    logic pop;

    assign push = pipe_valid_reg[PIPE_DEPTH-1] && pipe_go;
    assign pop = vc_valid && vc_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            buf_cnt_reg <= 2'd0;
            buf_rd_reg <= 1'b0;
            buf_wr_reg <= 1'b0;
        end else begin
            if (push) begin
                buf_reg[buf_wr_reg] <= map_word;
                buf_wr_reg <= ~buf_wr_reg;
            end
            if (pop) begin
                buf_rd_reg <= ~buf_rd_reg;
            end
            buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // registered view of the head entry; buffer also stalls the pipeline
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vc_valid <= 1'b0;
            vc_word <= '0;
            vc_ctrl_bit <= '0;
            in_ready <= 1'b1;
        end else begin
            logic [1:0] cnt_n;
            logic rd_n;
            cnt_n = buf_cnt_reg + {1'b0, push} - {1'b0, pop};
            rd_n = pop ? ~buf_rd_reg : buf_rd_reg;
            vc_valid <= (cnt_n != 2'd0);
            if (cnt_n == 2'd0) begin
                vc_word <= '0;
            end else if (buf_cnt_reg == 2'd0 || (buf_cnt_reg == 2'd1 && pop)) begin
                vc_word <= map_word;
            end else begin
                vc_word <= buf_reg[rd_n];
            end
            if (control_bits_per_sample != 2'd0) begin
                vc_ctrl_bit <= (cnt_n == 2'd0) ? 8'h00 :
                    ((buf_cnt_reg == 2'd0 || (buf_cnt_reg == 2'd1 && pop)) ? map_word.overrange
                    : buf_reg[rd_n].overrange);
            end else begin
                vc_ctrl_bit <= 8'h00;
            end
            in_ready <= (cnt_n != 2'd2); // buffer full holds the pipeline
        end
    end

    // ====================================================================
    // assertions
    property p_flag_clear_needs_low;
        @(posedge clk) disable iff (!arst_n)
        $fell(flag_reg[0]) |-> $past(mag_valid_reg[0]) && ({3'b000, $past(mag_reg[0])} < $past(lower_reg));
    endproperty
    a_flag_clear_needs_low: assert property (p_flag_clear_needs_low) else $error("flag cleared above lower");

    property p_flag_set_fast;
        @(posedge clk) disable iff (!arst_n)
        (mag_valid_reg[0] && ({3'b000, mag_reg[0]} > upper_reg)) |=> flag_reg[0] ##1 threshold_flag_pin_first;
    endproperty
    a_flag_set_fast: assert property (p_flag_set_fast) else $error("flag late after upper crossing");

    property p_sticky_holds;
        @(posedge clk) disable iff (!arst_n)
        (ovr_sticky_reg[0] && clear_fall[0] == 1'b0) |=> ovr_sticky_reg[0];
    endproperty
    a_sticky_holds: assert property (p_sticky_holds) else $error("sticky bit lost");

    property p_sticky_clears;
        @(posedge clk) disable iff (!arst_n)
        (clear_fall[1] && !ovr_set[1]) |=> !ovr_sticky_reg[1];
    endproperty
    a_sticky_clears: assert property (p_sticky_clears) else $error("sticky bit not cleared");

    property p_ctrl_bit_follows;
        @(posedge clk) disable iff (!arst_n)
        (control_bits_per_sample != 2'd0) |=> (vc_ctrl_bit == vc_word.overrange);
    endproperty
    a_ctrl_bit_follows: assert property (p_ctrl_bit_follows) else $error("control bits differ from overrange");

    property p_pin_second_follows;
        @(posedge clk) disable iff (!arst_n)
        threshold_flag_pin_second == $past(flag_reg[1]);
    endproperty
    a_pin_second_follows: assert property (p_pin_second_follows) else $error("second pin not following flag");
endmodule : ofd_top

/* dv/ofd_sink.sv */
module ofd_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic vc_valid,
    input wire ofd_pkg::ofd_vc_word_t vc_word,
    input wire logic [7:0] vc_ctrl_bit,
    input wire logic [1:0] stall,
    output logic vc_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    ofd_pkg::ofd_vc_word_t got_w[$];
    logic [7:0] got_c[$];
    // ====================
    // link receiver: takes a word on the edge where valid and ready are both high
    // stall 0 always ready, 1 random ready, 2 holds ready low
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vc_ready <= 1'b0;
        end else begin
            if (vc_valid && vc_ready) begin
                got_w.push_back(vc_word);
                got_c.push_back(vc_ctrl_bit);
            end
            vc_ready <= (stall == 2'h0) || (stall == 2'h1 && $urandom_range(1) == 1);
        end
    end
endmodule : ofd_sink

/* dv/ofd_top_tb.sv */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module ofd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, reg_wr, reg_rd, ddc_valid, fd_a, fd_b, vc_valid, vc_ready, in_ready;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, vc_ctrl_bit;
    logic [1:0] cbps, stall;
    logic [3:0] dec_ratio, chip_mode;
    ofd_pkg::ofd_sample_t adc_a, adc_b;
    logic [ofd_pkg::NUM_DDC-1:0][ofd_pkg::SAMPLE_W-1:0] ddc_i, ddc_q;
    ofd_pkg::ofd_vc_word_t vc_word, ew;
    int fail_count, comparisons;
    localparam logic [15:0] ADR [10] = '{ofd_pkg::ADDR_APP_MODE, ofd_pkg::ADDR_DEC_RATIO, ofd_pkg::ADDR_UPPER_LO,
        ofd_pkg::ADDR_UPPER_HI, ofd_pkg::ADDR_LOWER_LO, ofd_pkg::ADDR_LOWER_HI, ofd_pkg::ADDR_DWELL_LO,
        ofd_pkg::ADDR_DWELL_HI, ofd_pkg::ADDR_OVR_CLEAR, ofd_pkg::ADDR_OVR_STATUS};
    localparam logic [7:0] RST [10] = '{8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MSK [10] = '{8'h2F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] FDV [6] = '{8'h00, 8'h08, 8'h00, 8'h04, 8'h03, 8'h00};

    ofd_top #(.PIPE_DEPTH(4)) ofd_top_inst (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .control_bits_per_sample(cbps),
        .adc_a(adc_a), .adc_b(adc_b), .ddc_i(ddc_i), .ddc_q(ddc_q), .ddc_valid(ddc_valid),
        .threshold_flag_pin_first(fd_a), .threshold_flag_pin_second(fd_b), .vc_valid(vc_valid),
        .vc_ready(vc_ready), .vc_word(vc_word), .vc_ctrl_bit(vc_ctrl_bit), .dec_ratio(dec_ratio),
        .chip_mode(chip_mode), .in_ready(in_ready));
    ofd_sink ofd_sink_inst (.clk(clk), .arst_n(arst_n), .vc_valid(vc_valid), .vc_word(vc_word),
        .vc_ctrl_bit(vc_ctrl_bit), .stall(stall), .vc_ready(vc_ready));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ====================
    // bus and stream tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic rnd(input logic oa, input logic ob);
        adc_a = '{1'b1, oa, 14'($urandom)};
        adc_b = '{1'b1, ob, 14'($urandom)};
        for (int k = 0; k < 4; k++) begin
            ddc_i[k] = 14'($urandom);
            ddc_q[k] = 14'($urandom);
        end
        ddc_valid = 1'b1;
    endtask : rnd
    task automatic idle();
        adc_a.valid = 1'b0;
        adc_b.valid = 1'b0;
        ddc_valid = 1'b0;
    endtask : idle
    task automatic get(output ofd_pkg::ofd_vc_word_t w, output logic [7:0] c);
        int t;
        t = 0;
        while (ofd_sink_inst.got_w.size() == 0 && t < 40) begin
            @(negedge clk);
            t++;
        end
        `CHK(t < 40, 1'b1)
        w = ofd_sink_inst.got_w.pop_front();
        c = ofd_sink_inst.got_c.pop_front();
    endtask : get
    // expected slot contents for the sample now on the inputs
    function automatic ofd_pkg::ofd_vc_word_t exp_word(input logic [3:0] m, input logic qi);
        ofd_pkg::ofd_vc_word_t w;
        int n;
        logic o;
        w = '0;
        n = (m == 4'h3) ? 4 : int'(m);
        o = adc_a.overrange | adc_b.overrange;
        if (m == 4'h0) begin
            w.used = 8'h03;
            w.overrange = {6'h00, adc_b.overrange, adc_a.overrange};
            w.data[0] = adc_a.data;
            w.data[1] = adc_b.data;
        end else begin
            for (int k = 0; k < n; k++) begin
                if (qi) begin
                    w.used[k] = 1'b1;
                    w.overrange[k] = o;
                    w.data[k] = ddc_i[k];
                end else begin
                    w.used[2*k+:2] = 2'h3;
                    w.overrange[2*k+:2] = {o, o};
                    w.data[2*k] = ddc_i[k];
                    w.data[2*k+1] = ddc_q[k];
                end
            end
        end
        return w;
    endfunction : exp_word
    // kind 0 over then below, 1 adds a sample at the lower level, 2 equal to upper
    task automatic fd_run(input int ch, input int kind, output int first, output int hi, output int other);
        logic [13:0] s;
        first = -1;
        hi = 0;
        other = 0;
        for (int t = 0; t < 60; t++) begin
            @(negedge clk);
            if (kind == 2) s = 14'h0800;
            else if (t == 0) s = ch ? 14'h3448 : 14'h0BB8;
            else if (kind == 1 && t == 3) s = 14'h0400;
            else s = 14'h0064;
            adc_a = '{1'b1, 1'b0, ch ? 14'h0000 : s};
            adc_b = '{1'b1, 1'b0, ch ? s : 14'h0000};
            if ((ch ? fd_b : fd_a) === 1'b1) begin
                hi++;
                if (first < 0) first = t;
            end
            if ((ch ? fd_a : fd_b) !== 1'b0) other++;
        end
    endtask : fd_run
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #400000;
        fail_count++;
        results();
    end
    // ====================
    // main sequence
    initial begin
        logic [7:0] r, d, c;
        ofd_pkg::ofd_vc_word_t w, q[$];
        int f, h0, h1, h2, o0, o1, o2, low;
        void'($urandom(32'hbe74));
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, cbps, stall, ddc_valid} = '0;
        {adc_a, adc_b, ddc_i, ddc_q} = '0;
        repeat (16) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        `CHK({in_ready, dec_ratio, chip_mode}, 9'h110)
        for (int i = 0; i < 10; i++) begin
            rd(ADR[i], r);
            `CHK(r, RST[i])
        end
        rd(16'h0300, r);
        `CHK(r, 8'h00)
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            d = 8'($urandom);
            wr(ADR[i], d);
            rd(ADR[i], r);
            `CHK(r & MSK[i], (i == 9 ? 8'h00 : d) & MSK[i])
            if (i == 0) `CHK(chip_mode, d[3:0])
            if (i == 1) `CHK(dec_ratio, d[3:0])
        end
        $display("test register access done");
        for (int i = 2; i < 8; i++) wr(ADR[i], FDV[i-2]);
        for (int ch = 0; ch < 2; ch++) begin
            fd_run(ch, 0, f, h0, o0);
            `CHK(f >= 0 && f <= 28, 1'b1)
            `CHK(h0 >= 3 && h0 <= 7, 1'b1)
            fd_run(ch, 1, f, h1, o1);
            `CHK(h1, h0 + 3)
            fd_run(ch, 2, f, h2, o2);
            `CHK(h2, 0)
            `CHK(o0 + o1 + o2, 0)
        end
        idle();
        repeat (12) @(negedge clk);
        ofd_sink_inst.got_w.delete();
        ofd_sink_inst.got_c.delete();
        $display("test fast detect done");
        for (int m = 0; m < 4; m++) for (int qi = 0; qi < 2; qi++) begin
            if (m == 0 && qi == 1) continue;
            wr(ofd_pkg::ADDR_APP_MODE, {2'h0, qi[0], 1'b0, m[3:0]});
            cbps = 2'($urandom);
            rnd(1'($urandom), 1'($urandom));
            ew = exp_word(m[3:0], qi[0]);
            @(negedge clk);
            idle();
            get(w, c);
            `CHK(w, ew)
            `CHK(c, (cbps != 2'h0) ? ew.overrange : 8'h00)
        end
        $display("test mapping done");
        wr(ofd_pkg::ADDR_OVR_CLEAR, 8'hFF);
        wr(ofd_pkg::ADDR_OVR_CLEAR, 8'h00);
        rd(ofd_pkg::ADDR_OVR_STATUS, r);
        `CHK(r, 8'h00)
        wr(ofd_pkg::ADDR_APP_MODE, 8'h03);
        rnd(1'b1, 1'b0);
        @(negedge clk);
        idle();
        get(w, c);
        rd(ofd_pkg::ADDR_OVR_STATUS, r);
        `CHK(r, 8'hFF)
        wr(ofd_pkg::ADDR_OVR_CLEAR, 8'h0F);
        wr(ofd_pkg::ADDR_OVR_CLEAR, 8'h00);
        rd(ofd_pkg::ADDR_OVR_STATUS, r);
        `CHK(r, 8'hF0)
        $display("test sticky overrange done");
        wr(ofd_pkg::ADDR_APP_MODE, 8'h00);
        low = 0;
        for (int t = 0; t < 50; t++) begin
            stall = (t < 12) ? 2'h2 : 2'h1;
            @(negedge clk);
            if (in_ready === 1'b1) begin
                rnd(1'b0, 1'b0);
                q.push_back(exp_word(4'h0, 1'b0));
            end else begin
                idle();
                low++;
            end
        end
        @(negedge clk);
        idle();
        `CHK(low > 0, 1'b1)
        foreach (q[i]) begin
            get(w, c);
            `CHK(w, q[i])
        end
        $display("test stalled stream done");
        results();
    end
endmodule : ofd_top_tb
